// File: hw/gpps_defines.svh
// Purpose: Named offsets, field positions and reset values for the port
// Assumes: Included by its bare name from the port module
// Notes: Definitions only
`ifndef GPPS_DEFINES_SVH
`define GPPS_DEFINES_SVH

// Register byte offsets on the AXI4-Lite bus
`define GPPS_OFF_VALUE 8'h00
`define GPPS_OFF_LATCH 8'h04
`define GPPS_OFF_DIR 8'h08
`define GPPS_OFF_ANSEL 8'h0C
`define GPPS_OFF_STEER 8'h10

// Port A implemented bits and reset values
`define GPPS_PA_MASK 6'h37
`define GPPS_DIR_FORCED1 6'h08
`define GPPS_DIR_RST 6'h37
`define GPPS_ANSEL_RST 6'h37
`define GPPS_LATCH_RST 6'h00
`define GPPS_STEER_RST 8'h00

// Implemented steering bits per package variant
`define GPPS_IMPL_PIN14 8'hF7
`define GPPS_IMPL_PIN20 8'h33

// Steering field positions
`define GPPS_RX_SEL 7
`define GPPS_SDO_SEL 6
`define GPPS_SS_SEL 5
`define GPPS_SD_SEL 4
`define GPPS_UNUSED_SEL 3
`define GPPS_TX_SEL 2
`define GPPS_GB_SEL 1
`define GPPS_GA_SEL 0

// Pin positions within their ports
`define GPPS_PA3 3
`define GPPS_PA4 4
`define GPPS_PC1 3'h1
`define GPPS_PC2 3'h2
`define GPPS_PC3 3'h3
`define GPPS_PC4 3'h4
`define GPPS_PC5 3'h5
`define GPPS_PC6 3'h6

// Bus responses
`define GPPS_RESP_OKAY 2'h0
`define GPPS_RESP_SLVERR 2'h2

`endif

// File: hw/gpps_pkg.sv
// Purpose: Types shared by the port logic and its bench
// Assumes: Nothing
// Notes: Offsets and values live in gpps_defines.svh
package gpps_pkg;

	// Package variant of the device
	typedef enum {GPPS_PIN14, GPPS_PIN20} gpps_variant_e;

	// Register selected by a bus address
	typedef enum {GPPS_REG_VALUE, GPPS_REG_LATCH, GPPS_REG_DIR,
		GPPS_REG_ANSEL, GPPS_REG_STEER, GPPS_REG_NONE} gpps_reg_e;

endpackage

// File: hw/gpps_gpio_port.sv
// Purpose: Port A GPIO with pin steering of peripheral signals
// Assumes: One 200 MHz clock; pins and pads are asynchronous
// Notes: Port B/C GPIO lives elsewhere; this only claims their pins
`timescale 1ns/1ps
`include "gpps_defines.svh"

module gpps_gpio_port #(
	parameter gpps_pkg::gpps_variant_e VARIANT = gpps_pkg::GPPS_PIN14,
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// AXI4-Lite write address and data
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Port A pads
	input wire logic [5:0] paPinIn,
	output logic [5:0] paPinOut,
	output logic [5:0] paPinOe,
	output logic [5:0] paInBufEn,
	// Port C pads claimed by steered peripherals
	input wire logic [7:0] pcPinIn,
	output logic [7:0] pcPerOwn,
	output logic [7:0] pcPerOut,
	output logic [7:0] pcPerOe,
	// Port B pin 4 claimed by serial in on the larger package
	input wire logic pbPin4In,
	output logic pbPin4Own,
	output logic pbPin4Out,
	output logic pbPin4Oe,
	// Receive / synchronous data function
	input wire logic receiveSyncDataEn,
	input wire logic receiveSyncDataOut,
	input wire logic receiveSyncDataOe,
	output logic receiveSyncDataIn,
	// Transmit / synchronous clock function
	input wire logic transmitSyncClockEn,
	input wire logic transmitSyncClockOut,
	input wire logic transmitSyncClockOe,
	output logic transmitSyncClockIn,
	// Serial data out and slave select
	input wire logic serialDataOutEn,
	input wire logic serialDataOutOut,
	input wire logic slaveSelectEn,
	output logic slaveSelectIn,
	// Serial data in, doubling as I2C data
	input wire logic serialDataInEn,
	input wire logic serialDataInOut,
	input wire logic serialDataInOe,
	output logic serialDataInIn,
	// Converter guard ring drives
	input wire logic conv1GuardAEn,
	input wire logic conv1GuardAOut,
	input wire logic conv1GuardBEn,
	input wire logic conv1GuardBOut,
	input wire logic conv2GuardAEn,
	input wire logic conv2GuardAOut,
	input wire logic conv2GuardBEn,
	input wire logic conv2GuardBOut
);

	localparam bit IS_PIN14 = (VARIANT == gpps_pkg::GPPS_PIN14);
	localparam logic [7:0] STEER_IMPL =
		IS_PIN14 ? `GPPS_IMPL_PIN14 : `GPPS_IMPL_PIN20;

	logic [5:0] latchReg;
	logic [5:0] dirReg;
	logic [5:0] anselReg;
	logic [7:0] steerReg;
	logic [5:0] paSyncA, paSyncB;
	logic [7:0] pcSyncA, pcSyncB;
	logic pbSyncA, pbSyncB;
	logic [5:0] paDigIn;
	logic [ADDR_W-1:0] awAddrReg;
	logic awHeld, wHeld;
	logic [7:0] wByteReg;
	logic wStrbReg;
	logic doWrite;
	gpps_pkg::gpps_reg_e wrSel;
	logic [5:0] paOwn, paPerOut, paPerOe;
	logic [7:0] pcOwnNext, pcOutNext, pcOeNext;
	logic pbOwnNext, pbOutNext, pbOeNext;
	logic [2:0] gIdx;

	// Address decode shared by read and write paths
	function automatic gpps_pkg::gpps_reg_e decodeReg(
		input logic [ADDR_W-1:0] addr);
		logic [7:0] off;
		off = addr[7:0];
		case (off)
			`GPPS_OFF_VALUE: decodeReg = gpps_pkg::GPPS_REG_VALUE;
			`GPPS_OFF_LATCH: decodeReg = gpps_pkg::GPPS_REG_LATCH;
			`GPPS_OFF_DIR: decodeReg = gpps_pkg::GPPS_REG_DIR;
			`GPPS_OFF_ANSEL: decodeReg = gpps_pkg::GPPS_REG_ANSEL;
			`GPPS_OFF_STEER: decodeReg = gpps_pkg::GPPS_REG_STEER;
			default: decodeReg = gpps_pkg::GPPS_REG_NONE;
		endcase
	endfunction

	// Pad synchronisers; first stage feeds only the second
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			paSyncA <= 6'h00;
			paSyncB <= 6'h00;
			pcSyncA <= 8'h00;
			pcSyncB <= 8'h00;
			pbSyncA <= 1'h0;
			pbSyncB <= 1'h0;
		end
		else
		begin
			paSyncA <= paPinIn;
			paSyncB <= paSyncA;
			pcSyncA <= pcPinIn;
			pcSyncB <= pcSyncA;
			pbSyncA <= pbPin4In;
			pbSyncB <= pbSyncA;
		end
	end

	// Analog pins read as zero; PA3 has no analog select
	assign paDigIn = paSyncB & ~anselReg;

	// Write channel acceptance; either order, one write at a time
	assign awready = !awHeld && !bvalid;
	assign wready = !wHeld && !bvalid;
	assign doWrite = awHeld && wHeld && !bvalid;
	assign wrSel = decodeReg(awAddrReg);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			awHeld <= 1'h0;
			wHeld <= 1'h0;
			awAddrReg <= '0;
			wByteReg <= 8'h00;
			wStrbReg <= 1'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				awHeld <= 1'h1;
				awAddrReg <= awaddr;
			end
			else if (doWrite)
				awHeld <= 1'h0;
			if (wvalid && wready)
			begin
				wHeld <= 1'h1;
				wByteReg <= wdata[7:0];
				wStrbReg <= wstrb[0];
			end
			else if (doWrite)
				wHeld <= 1'h0;
		end
	end

	// Write response follows the register update edge
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bvalid <= 1'h0;
			bresp <= `GPPS_RESP_OKAY;
		end
		else if (doWrite)
		begin
			bvalid <= 1'h1;
			bresp <= (wrSel == gpps_pkg::GPPS_REG_NONE) ?
				`GPPS_RESP_SLVERR : `GPPS_RESP_OKAY;
		end
		else if (bready)
			bvalid <= 1'h0;
	end

	// Output latch; value writes merge pins so an empty lane re-latches
	// the pin levels, the usual read-modify-write hazard
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			latchReg <= `GPPS_LATCH_RST;
		else if (doWrite && wrSel == gpps_pkg::GPPS_REG_LATCH && wStrbReg)
			latchReg <= wByteReg[5:0] & `GPPS_PA_MASK;
		else if (doWrite && wrSel == gpps_pkg::GPPS_REG_VALUE)
			latchReg <= (wStrbReg ? wByteReg[5:0] : paDigIn)
				& `GPPS_PA_MASK;
	end

	// Direction and analog select; pins power up as analog inputs, except PA3, a digital input
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dirReg <= `GPPS_DIR_RST;
			anselReg <= `GPPS_ANSEL_RST;
		end
		else if (doWrite && wStrbReg)
		begin
			if (wrSel == gpps_pkg::GPPS_REG_DIR)
				dirReg <= wByteReg[5:0] & `GPPS_PA_MASK;
			if (wrSel == gpps_pkg::GPPS_REG_ANSEL)
				anselReg <= wByteReg[5:0] & `GPPS_PA_MASK;
		end
	end

	// Steering; bits missing on the package stay zero
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			steerReg <= `GPPS_STEER_RST;
		else if (doWrite && wStrbReg && wrSel == gpps_pkg::GPPS_REG_STEER)
			steerReg <= wByteReg & STEER_IMPL;
	end

	// Read channel; data captured at address acceptance
	assign arready = !rvalid;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rvalid <= 1'h0;
			rdata <= 32'h0000_0000;
			rresp <= `GPPS_RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'h1;
			rresp <= `GPPS_RESP_OKAY;
			case (decodeReg(araddr))
				gpps_pkg::GPPS_REG_VALUE:
					rdata <= {26'h0, paDigIn};
				gpps_pkg::GPPS_REG_LATCH:
					rdata <= {26'h0, latchReg};
				gpps_pkg::GPPS_REG_DIR:
					rdata <= {26'h0, dirReg | `GPPS_DIR_FORCED1};
				gpps_pkg::GPPS_REG_ANSEL:
					rdata <= {26'h0, anselReg};
				gpps_pkg::GPPS_REG_STEER:
					rdata <= {24'h0, steerReg};
				default:
				begin
					rdata <= 32'h0000_0000;
					rresp <= `GPPS_RESP_SLVERR;
				end
			endcase
		end
		else if (rready)
			rvalid <= 1'h0;
	end

	// Pin claims by steered functions; later claims win a shared pin
	always_comb
	begin
		paOwn = 6'h00;
		paPerOut = 6'h00;
		paPerOe = 6'h00;
		pcOwnNext = 8'h00;
		pcOutNext = 8'h00;
		pcOeNext = 8'h00;
		pbOwnNext = 1'h0;
		pbOutNext = 1'h0;
		pbOeNext = 1'h0;
		gIdx = `GPPS_PC2;
		// Guard rings, lowest priority
		if (conv1GuardBEn)
		begin
			gIdx = steerReg[`GPPS_GB_SEL] ? `GPPS_PC3 : `GPPS_PC2;
			pcOwnNext[gIdx] = 1'h1;
			pcOutNext[gIdx] = conv1GuardBOut;
			pcOeNext[gIdx] = 1'h1;
		end
		if (conv2GuardBEn)
		begin
			gIdx = steerReg[`GPPS_GB_SEL] ? `GPPS_PC2 : `GPPS_PC3;
			pcOwnNext[gIdx] = 1'h1;
			pcOutNext[gIdx] = conv2GuardBOut;
			pcOeNext[gIdx] = 1'h1;
		end
		if (conv1GuardAEn)
		begin
			gIdx = steerReg[`GPPS_GA_SEL] ? `GPPS_PC5 : `GPPS_PC4;
			pcOwnNext[gIdx] = 1'h1;
			pcOutNext[gIdx] = conv1GuardAOut;
			pcOeNext[gIdx] = 1'h1;
		end
		if (conv2GuardAEn)
		begin
			gIdx = steerReg[`GPPS_GA_SEL] ? `GPPS_PC4 : `GPPS_PC5;
			pcOwnNext[gIdx] = 1'h1;
			pcOutNext[gIdx] = conv2GuardAOut;
			pcOeNext[gIdx] = 1'h1;
		end
		// Slave select is an input; its pin is only fenced off
		if (slaveSelectEn && steerReg[`GPPS_SS_SEL])
		begin
			gIdx = IS_PIN14 ? `GPPS_PC3 : `GPPS_PC6;
			pcOwnNext[gIdx] = 1'h1;
			pcOeNext[gIdx] = 1'h0;
		end
		// Transmit / clock with its own direction override
		if (transmitSyncClockEn)
		begin
			gIdx = steerReg[`GPPS_TX_SEL] ? `GPPS_PC3 : `GPPS_PC4;
			pcOwnNext[gIdx] = 1'h1;
			pcOutNext[gIdx] = transmitSyncClockOut;
			pcOeNext[gIdx] = transmitSyncClockOe;
		end
		// Serial in / I2C data; PA3 cannot drive, so no claim there
		if (serialDataInEn && !steerReg[`GPPS_SD_SEL])
		begin
			if (IS_PIN14)
			begin
				pcOwnNext[`GPPS_PC1] = 1'h1;
				pcOutNext[`GPPS_PC1] = serialDataInOut;
				pcOeNext[`GPPS_PC1] = serialDataInOe;
			end
			else
			begin
				pbOwnNext = 1'h1;
				pbOutNext = serialDataInOut;
				pbOeNext = serialDataInOe;
			end
		end
		// Serial data out
		if (serialDataOutEn)
		begin
			if (steerReg[`GPPS_SDO_SEL])
			begin
				paOwn[`GPPS_PA4] = 1'h1;
				paPerOut[`GPPS_PA4] = serialDataOutOut;
				paPerOe[`GPPS_PA4] = 1'h1;
			end
			else
			begin
				pcOwnNext[`GPPS_PC2] = 1'h1;
				pcOutNext[`GPPS_PC2] = serialDataOutOut;
				pcOeNext[`GPPS_PC2] = 1'h1;
			end
		end
		// Receive / data, highest priority
		if (receiveSyncDataEn)
		begin
			if (steerReg[`GPPS_RX_SEL])
			begin
				paOwn[`GPPS_PA4] = 1'h1;
				paPerOut[`GPPS_PA4] = receiveSyncDataOut;
				paPerOe[`GPPS_PA4] = receiveSyncDataOe;
			end
			else
			begin
				pcOwnNext[`GPPS_PC5] = 1'h1;
				pcOutNext[`GPPS_PC5] = receiveSyncDataOut;
				pcOeNext[`GPPS_PC5] = receiveSyncDataOe;
			end
		end
	end

	// Pad drive registers; analog select gates only the input buffer enable, not the drive
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			paPinOut <= 6'h00;
			paPinOe <= 6'h00;
			paInBufEn <= 6'h00;
			pcPerOwn <= 8'h00;
			pcPerOut <= 8'h00;
			pcPerOe <= 8'h00;
			pbPin4Own <= 1'h0;
			pbPin4Out <= 1'h0;
			pbPin4Oe <= 1'h0;
		end
		else
		begin
			paPinOut <= (paOwn & paPerOut) | (~paOwn & latchReg);
			paPinOe <= ((paOwn & paPerOe) | (~paOwn & ~dirReg))
				& `GPPS_PA_MASK;
			paInBufEn <= ~anselReg;
			pcPerOwn <= pcOwnNext;
			pcPerOut <= pcOutNext;
			pcPerOe <= pcOeNext;
			pbPin4Own <= pbOwnNext;
			pbPin4Out <= pbOutNext;
			pbPin4Oe <= pbOeNext;
		end
	end

	// Steered inputs back to the peripherals
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			receiveSyncDataIn <= 1'h0;
			transmitSyncClockIn <= 1'h0;
			slaveSelectIn <= 1'h0;
			serialDataInIn <= 1'h0;
		end
		else
		begin
			receiveSyncDataIn <= steerReg[`GPPS_RX_SEL] ?
				paDigIn[`GPPS_PA4] : pcSyncB[`GPPS_PC5];
			transmitSyncClockIn <= steerReg[`GPPS_TX_SEL] ?
				pcSyncB[`GPPS_PC3] : pcSyncB[`GPPS_PC4];
			slaveSelectIn <= !steerReg[`GPPS_SS_SEL] ? paDigIn[`GPPS_PA3]
				: (IS_PIN14 ? pcSyncB[`GPPS_PC3]
				: pcSyncB[`GPPS_PC6]);
			serialDataInIn <= steerReg[`GPPS_SD_SEL] ? paDigIn[`GPPS_PA3]
				: (IS_PIN14 ? pcSyncB[`GPPS_PC1] : pbSyncB);
		end
	end

	// Checks on the logic above
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	AST_LATCH_WRITE: assert property (
		doWrite && wStrbReg && wrSel == gpps_pkg::GPPS_REG_LATCH
		|=> latchReg == ($past(wByteReg[5:0]) & `GPPS_PA_MASK))
		else $error("latch write not stored");
	AST_VALUE_RMW: assert property (
		doWrite && !wStrbReg && wrSel == gpps_pkg::GPPS_REG_VALUE
		|=> latchReg == ($past(paDigIn) & `GPPS_PA_MASK))
		else $error("value write did not relatch pins");
	AST_PA3_DIR_READ: assert property (
		arvalid && arready && decodeReg(araddr) == gpps_pkg::GPPS_REG_DIR
		|=> rvalid && rdata[`GPPS_PA3] && !paPinOe[`GPPS_PA3])
		else $error("PA3 direction not forced to input");
	AST_ANALOG_READ_ZERO: assert property (
		arvalid && arready && decodeReg(araddr) == gpps_pkg::GPPS_REG_VALUE
		|=> (rdata[5:0] & $past(anselReg)) == 6'h00)
		else $error("analog pin read nonzero");
	AST_STEER_BIT3: assert property (
		arvalid && arready && decodeReg(araddr) == gpps_pkg::GPPS_REG_STEER
		|=> !rdata[`GPPS_UNUSED_SEL] && rdata[31:8] == 24'h0)
		else $error("steering bit 3 read as one");
	AST_GPIO_DRIVE: assert property (
		!paOwn[`GPPS_PA4] && !dirReg[`GPPS_PA4]
		|=> paPinOe[`GPPS_PA4] && paPinOut[`GPPS_PA4] ==
		$past(latchReg[`GPPS_PA4]))
		else $error("output pin not driving latch");
	AST_PERIPH_OWNS: assert property (
		serialDataOutEn && !receiveSyncDataEn && steerReg[`GPPS_SDO_SEL]
		|=> paPinOut[`GPPS_PA4] == $past(serialDataOutOut)
		&& paPinOe[`GPPS_PA4])
		else $error("GPIO drove a peripheral pin");
	AST_TX_ROUTE: assert property (
		transmitSyncClockEn && !receiveSyncDataEn
		|=> pcPerOwn[$past(steerReg[`GPPS_TX_SEL]) ? `GPPS_PC3 : `GPPS_PC4])
		else $error("transmit clock on wrong pin");
	AST_GUARD_B_SWAP: assert property (
		conv1GuardBEn && !conv2GuardBEn && !slaveSelectEn
		&& !transmitSyncClockEn && !serialDataOutEn && steerReg[`GPPS_GB_SEL]
		|=> pcPerOwn[`GPPS_PC3] && !pcPerOwn[`GPPS_PC2]
		&& pcPerOut[`GPPS_PC3] == $past(conv1GuardBOut))
		else $error("guard B not swapped");
	AST_ANALOG_KEEPS_OUT: assert property (
		anselReg[`GPPS_PA3 - 3] && !dirReg[`GPPS_PA3 - 3]
		|=> paPinOe[`GPPS_PA3 - 3] && !paInBufEn[`GPPS_PA3 - 3])
		else $error("analog select blocked output");

endmodule // gpps_gpio_port

// File: tb/gpps_pad_model.sv
// Purpose: Pad model resolving port A and port C pin levels
// Assumes: A design driver wins over the board source on a pin
// Notes: Released pads toggle each cycle, as no pull-up is modelled
`timescale 1ns/1ps

module gpps_pad_model (
	// Clock
	input wire logic clk,
	// Port A drive from the design and from the board
	input wire logic [5:0] paPinOut,
	input wire logic [5:0] paPinOe,
	input wire logic [5:0] extVal,
	input wire logic [5:0] extEn,
	output logic [5:0] paPinIn,
	// Port C drive from the steered peripherals
	input wire logic [7:0] pcPerOut,
	input wire logic [7:0] pcPerOe,
	output logic [7:0] pcPinIn
);
	logic [7:0] floatPat = 8'h55;

	// Floating pads flip so a stale level never reads back as a match
	always_ff @(posedge clk)
		floatPat <= ~floatPat;

	// Design driver first, then the board, else the floating pattern
	assign paPinIn = (paPinOe & paPinOut) | (~paPinOe & extEn & extVal)
		| (~paPinOe & ~extEn & floatPat[5:0]);
	assign pcPinIn = (pcPerOe & pcPerOut) | (~pcPerOe & floatPat);
endmodule // gpps_pad_model

// File: tb/gpio_port_with_pin_steering_tb.sv
// Purpose: Register and pin checks of the port with pin steering
// Assumes: Both package variants; bus tasks sample handshakes mid-cycle
// Notes: Board drives PA3 high so the input-only pin has a level
`timescale 1ns/1ps
`include "gpps_defines.svh"

module gpio_port_with_pin_steering_tb;
	logic clk, reset_n;
	logic [7:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata, got, rdata20, got20;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic [5:0] paPinIn, paPinOut, paPinOe, paInBufEn, extVal, extEn;
	logic [7:0] pcPinIn, pcPerOwn, pcPerOut, pcPerOe, own20;
	logic pbPin4In, perOut, perOe, rxIn, ssIn, pbOwn20;
	logic [8:0] perEn;
	int err_total, total_checks;
	// Function order: rx, tx, sdo, ss, sdi, g1a, g1b, g2a, g2b
	logic [7:0] selTbl [9] = '{8'h80, 8'h04, 8'h40, 8'h20, 8'h10,
		8'h01, 8'h02, 8'h01, 8'h02};
	logic [7:0] ownA [9] = '{8'h20, 8'h10, 8'h04, 8'h00, 8'h02,
		8'h10, 8'h04, 8'h20, 8'h08};
	logic [7:0] ownB [9] = '{8'h00, 8'h08, 8'h00, 8'h08, 8'h00,
		8'h20, 8'h08, 8'h10, 8'h04};

	gpps_gpio_port dut (.clk, .reset_n, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.paPinIn, .paPinOut, .paPinOe, .paInBufEn, .pcPinIn, .pcPerOwn,
		.pcPerOut, .pcPerOe, .pbPin4In, .pbPin4Own(), .pbPin4Out(),
		.pbPin4Oe(), .receiveSyncDataEn(perEn[0]),
		.receiveSyncDataOut(perOut), .receiveSyncDataOe(perOe),
		.receiveSyncDataIn(rxIn), .transmitSyncClockEn(perEn[1]),
		.transmitSyncClockOut(perOut), .transmitSyncClockOe(perOe),
		.transmitSyncClockIn(), .serialDataOutEn(perEn[2]),
		.serialDataOutOut(perOut), .slaveSelectEn(perEn[3]),
		.slaveSelectIn(ssIn), .serialDataInEn(perEn[4]),
		.serialDataInOut(perOut), .serialDataInOe(perOe),
		.serialDataInIn(), .conv1GuardAEn(perEn[5]),
		.conv1GuardAOut(perOut), .conv1GuardBEn(perEn[6]),
		.conv1GuardBOut(perOut), .conv2GuardAEn(perEn[7]),
		.conv2GuardAOut(perOut), .conv2GuardBEn(perEn[8]),
		.conv2GuardBOut(perOut));

	gpps_pad_model pads (.clk, .paPinOut, .paPinOe, .extVal, .extEn,
		.paPinIn, .pcPerOut, .pcPerOe, .pcPinIn);

	// Larger package on the same bus; same timing, so only read data and pin claims checked
	gpps_gpio_port #(.VARIANT(gpps_pkg::GPPS_PIN20)) dut20 (
		.clk, .reset_n,
		.awaddr, .awvalid, .awready(), .wdata, .wstrb, .wvalid, .wready(),
		.bresp(), .bvalid(), .bready, .araddr, .arvalid, .arready(),
		.rdata(rdata20), .rresp(), .rvalid(), .rready, .paPinIn,
		.paPinOut(), .paPinOe(), .paInBufEn(), .pcPinIn, .pcPerOwn(own20),
		.pcPerOut(), .pcPerOe(), .pbPin4In, .pbPin4Own(pbOwn20),
		.pbPin4Out(), .pbPin4Oe(), .receiveSyncDataEn(perEn[0]),
		.receiveSyncDataOut(perOut), .receiveSyncDataOe(perOe),
		.receiveSyncDataIn(), .transmitSyncClockEn(perEn[1]),
		.transmitSyncClockOut(perOut), .transmitSyncClockOe(perOe),
		.transmitSyncClockIn(), .serialDataOutEn(perEn[2]),
		.serialDataOutOut(perOut), .slaveSelectEn(perEn[3]),
		.slaveSelectIn(), .serialDataInEn(perEn[4]),
		.serialDataInOut(perOut), .serialDataInOe(perOe),
		.serialDataInIn(), .conv1GuardAEn(perEn[5]),
		.conv1GuardAOut(perOut), .conv1GuardBEn(perEn[6]),
		.conv1GuardBOut(perOut), .conv2GuardAEn(perEn[7]),
		.conv2GuardAOut(perOut), .conv2GuardBEn(perEn[8]),
		.conv2GuardBOut(perOut));

	// Free-running system clock
	initial
	begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end

	// Verdict, reached by the tests or by the watchdog
	task automatic tally_and_finish();
		if (err_total == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Compare and count; an unknown bit matches only an unknown bit
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Handshakes are judged mid-cycle, then acted on at the edge
	task automatic axw(input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s);
		int n;
		logic ah, wh, bh;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'h1;
		wdata <= {24'h000000, d};
		wstrb <= s;
		wvalid <= 1'h1;
		bready <= 1'h1;
		bh = 1'h0;
		n = 0;
		while (!bh && n < 50)
		begin
			@(negedge clk);
			ah = awvalid & awready;
			wh = wvalid & wready;
			bh = bvalid & bready;
			resp = bresp;
			@(posedge clk);
			if (ah) awvalid <= 1'h0;
			if (wh) wvalid <= 1'h0;
			n++;
		end
		bready <= 1'h0;
		if (!bh) err_total++;
	endtask

	task automatic axr(input logic [7:0] a);
		int n;
		logic ah, rh;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		rh = 1'h0;
		n = 0;
		while (!rh && n < 50)
		begin
			@(negedge clk);
			ah = arvalid & arready;
			rh = rvalid & rready;
			got = rdata;
			got20 = rdata20;
			resp = rresp;
			@(posedge clk);
			if (ah) arvalid <= 1'h0;
			n++;
		end
		rready <= 1'h0;
		if (!rh) err_total++;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		axr(a);
		chk(got, e);
		chk(32'(resp), 32'(`GPPS_RESP_OKAY));
	endtask

	// Pin outputs trail their cause by one edge, inputs by three
	task automatic settle();
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask

	// Hang guard, well beyond the few hundred cycles of the tests
	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		tally_and_finish();
	end

	// Main sequence
	initial
	begin
		reset_n = 1'h0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{extVal, extEn, pbPin4In, perEn, perOut, perOe} = '0;
		err_total = 0;
		total_checks = 0;
		extVal = 6'h08;
		extEn = 6'h3F;
		repeat (12) @(posedge clk);
		reset_n <= 1'h1;
		settle();
		chk(32'(paInBufEn), 32'h08);
		chk(32'(paPinOe), 32'h00);
		rdchk(`GPPS_OFF_DIR, 32'h3F);
		rdchk(`GPPS_OFF_ANSEL, 32'h37);
		rdchk(`GPPS_OFF_STEER, 32'h00);
		rdchk(`GPPS_OFF_VALUE, 32'h08);
		axw(`GPPS_OFF_LATCH, 8'h15, 4'h1);
		chk(32'(resp), 32'(`GPPS_RESP_OKAY));
		rdchk(`GPPS_OFF_LATCH, 32'h15);
		axw(`GPPS_OFF_VALUE, 8'h2A, 4'h1);
		rdchk(`GPPS_OFF_LATCH, 32'h22);
		// Analog pins keep driving; software would normally avoid this
		axw(`GPPS_OFF_DIR, 8'h00, 4'h1);
		rdchk(`GPPS_OFF_DIR, 32'h08);
		settle();
		chk(32'(paPinOe), 32'h37);
		chk(32'(paPinOut & 6'h37), 32'h22);
		rdchk(`GPPS_OFF_VALUE, 32'h08);
		axw(`GPPS_OFF_ANSEL, 8'h00, 4'h1);
		settle();
		chk(32'(paInBufEn), 32'h3F);
		rdchk(`GPPS_OFF_VALUE, 32'h2A);
		// Board takes the pins; a strobe-less value write re-latches them
		axw(`GPPS_OFF_DIR, 8'h3F, 4'h1);
		extVal <= 6'h1D;
		settle();
		axw(`GPPS_OFF_VALUE, 8'h00, 4'h0);
		rdchk(`GPPS_OFF_LATCH, 32'h15);
		axw(`GPPS_OFF_STEER, 8'hFF, 4'h1);
		rdchk(`GPPS_OFF_STEER, 32'hF7);
		chk(got20, 32'h33);
		rdchk(`GPPS_OFF_DIR, 32'h3F);
		perOut <= 1'h1;
		perOe <= 1'h1;
		for (int i = 0; i < 9; i++)
		begin
			perEn <= 9'(1 << i);
			axw(`GPPS_OFF_STEER, 8'h00, 4'h1);
			settle();
			chk(32'(pcPerOwn), 32'(ownA[i]));
			if (i == 4) chk(32'(pbOwn20), 32'h1);
			axw(`GPPS_OFF_STEER, selTbl[i], 4'h1);
			settle();
			chk(32'(pcPerOwn), 32'(ownB[i]));
			chk(32'(pcPerOut), (i == 3) ? 32'h0 : 32'(ownB[i]));
			if (i == 3) chk(32'(own20), 32'h40);
		end
		// Receive function on PA4 overrides a latch high
		perEn <= 9'h001;
		perOut <= 1'h0;
		axw(`GPPS_OFF_DIR, 8'h00, 4'h1);
		axw(`GPPS_OFF_STEER, 8'h80, 4'h1);
		settle();
		chk(32'(paPinOe[4]), 32'h1);
		chk(32'(paPinOut[4]), 32'h0);
		chk(32'(rxIn), 32'h0);
		chk(32'(ssIn), 32'h1);
		rdchk(`GPPS_OFF_VALUE, 32'h0D);
		// Receive drive loops back through the pad to its input
		perOut <= 1'h1;
		settle();
		chk(32'(rxIn), 32'h1);
		chk(32'(paPinOut[4]), 32'h1);
		axr(8'h20);
		chk(got, 32'h0);
		chk(32'(resp), 32'(`GPPS_RESP_SLVERR));
		axw(8'h20, 8'hFF, 4'h1);
		chk(32'(resp), 32'(`GPPS_RESP_SLVERR));
		// Second reset mid-run brings the power-up state back
		reset_n <= 1'h0;
		repeat (2) @(posedge clk);
		reset_n <= 1'h1;
		settle();
		chk(32'(paInBufEn), 32'h08);
		rdchk(`GPPS_OFF_ANSEL, 32'h37);
		rdchk(`GPPS_OFF_STEER, 32'h00);
		tally_and_finish();
	end
endmodule // gpio_port_with_pin_steering_tb
